// ===== hw/eec_serial_eeprom_ctrl.sv
/*
  Serial EEPROM controller: station address load at reset, host operations.
  Assumes the host keeps off the command inputs while busy and until init done.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eec_defines.svh"

// Summary of operation
// R01: At reset read byte 00h; expect A5h.
// R02: Signature found: load six bytes into address.
// R03: Six bytes stored sets address-loaded bit.
// R04: No signature: stop, address-loaded stays clear.
// R05: Host reload repeats check and load.
// R06: Host waits for reset-time load first.
// R07: Host loads data before write operations.
// R08: Host sets busy; controller clears on completion.
// R09: Read result in data register when busy clears.
// R10: Host changes command only when not busy.
// R11: Host enables erase/write before modifying memory.
// R12: No answer within 30 ms: abandon, set timeout.
// R13: Interface disabled: pins become outputs or monitors.
// R14: Erase sends erase of the given location.
// R15: Erase-all sends bulk erase of the memory.
// R16: Disable makes memory ignore erase and write.
// R17: Memory addressed as 128 bytes.
// R18: Frame: select, start, opcode, address, data, ready.

module eec_serial_eeprom_ctrl import eec_pkg::*; #(
  parameter int TIMEOUT_CYC = `EEC_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        soft_reset,
  // Host command side
  input  wire logic [2:0]  eeprom_operation_field,
  input  wire logic [6:0]  eeprom_location_field,
  input  wire logic        busy_set,
  input  wire logic [7:0]  data_wr_value,
  input  wire logic        data_wr,
  // Host status side
  output logic             eeprom_operation_busy,
  output logic             eeprom_timeout_flag,
  output logic             address_loaded,
  output logic             init_done,
  output logic [7:0]       eeprom_data_reg,
  output logic [31:0]      station_address_low_reg,
  output logic [15:0]      station_address_high_reg,
  // Pin function control
  input  wire logic        link_disable,
  input  wire logic        gpio_monitor_sel,
  input  wire logic [1:0]  gpio_value,
  input  wire logic [1:0]  mii_monitor,
  // Serial pins
  output logic             eeprom_chip_select,
  output logic             eeprom_serial_clock,
  output logic             eeprom_serial_io_out,
  output logic             eeprom_serial_io_oe,
  input  wire logic        eeprom_serial_io_in
);

  eec_ctl_st_t st_r, st_nxt;
  eec_op_t     op_r, op_nxt, eop_r, eop_nxt;
  logic [6:0]  eloc_r, eloc_nxt;
  logic        estart_r, estart_nxt;
  logic [2:0]  idx_r, idx_nxt;
  logic [47:0] mac_r, mac_nxt;
  logic        busy_nxt, tmo_nxt, loaded_nxt, init_nxt;
  logic [7:0]  data_nxt;
  logic        cs_nxt, clk_nxt, io_nxt, oe_nxt;
  logic        e_done, e_to, e_cs, e_sck, e_dout, e_oe;
  logic [7:0]  e_rdata;

  // ****************************************************************
  // Link engine
  // ****************************************************************
  eec_link_engine #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_engine (
    .core_clk  (core_clk),
    .reset     (reset),
    .start     (estart_r),
    .abort     (soft_reset),
    .op        (eop_r),
    .loc       (eloc_r),
    .wdata     (eeprom_data_reg),
    .done      (e_done),
    .timed_out (e_to),
    .rdata     (e_rdata),
    .cs        (e_cs),
    .sck       (e_sck),
    .dout      (e_dout),
    .dout_oe   (e_oe),
    .din       (eeprom_serial_io_in)
  );

  // ****************************************************************
  // Control sequencer
  // ****************************************************************
  // Reset enters the signature read directly, so the load starts at once.
  always_comb begin
    st_nxt = st_r; op_nxt = op_r; eop_nxt = eop_r; eloc_nxt = eloc_r; estart_nxt = 1'b0;
    idx_nxt = idx_r; mac_nxt = mac_r; busy_nxt = eeprom_operation_busy;
    tmo_nxt = eeprom_timeout_flag; loaded_nxt = address_loaded; init_nxt = init_done;
    data_nxt = eeprom_data_reg;
    case (st_r)
      C_SIG_RD: begin
        eop_nxt = OP_READ; eloc_nxt = `EEC_SIG_LOC; estart_nxt = 1'b1;  // R01
        loaded_nxt = 1'b0;
        st_nxt = C_SIG_WAIT;
      end
      C_SIG_WAIT: if (e_done) begin
        if (!e_to && e_rdata == `EEC_SIG_VALUE) begin  // R01
          idx_nxt = 3'h0; st_nxt = C_MAC_RD;
        end else begin
          // Absent or blank memory: software must program the address.
          tmo_nxt = e_to; busy_nxt = 1'b0; init_nxt = 1'b1; st_nxt = C_IDLE;  // R04 R05
        end
      end
      C_MAC_RD: begin
        eop_nxt = OP_READ; eloc_nxt = {4'h0, idx_r} + 7'h01; estart_nxt = 1'b1;  // R02
        st_nxt = C_MAC_WAIT;
      end
      C_MAC_WAIT: if (e_done) begin
        if (e_to) begin
          tmo_nxt = 1'b1; busy_nxt = 1'b0; init_nxt = 1'b1; st_nxt = C_IDLE;
        end else begin
          mac_nxt[idx_r*8 +: 8] = e_rdata;  // R02
          if (idx_r == `EEC_MAC_BYTES - 3'h1) begin
            loaded_nxt = 1'b1; busy_nxt = 1'b0; init_nxt = 1'b1; st_nxt = C_IDLE;  // R03 R05
          end else begin
            idx_nxt = idx_r + 3'h1; st_nxt = C_MAC_RD;
          end
        end
      end
      C_IDLE: begin
        // The data register takes host writes only while no operation runs.
        if (data_wr && !eeprom_operation_busy) data_nxt = data_wr_value;  // R07
        if (busy_set) begin  // R08
          busy_nxt = 1'b1; tmo_nxt = 1'b0;
          op_nxt = eec_op_t'(eeprom_operation_field);
          if (eec_op_t'(eeprom_operation_field) == OP_RELOAD) begin
            st_nxt = C_SIG_RD;  // R05
          end else begin
            eop_nxt = eec_op_t'(eeprom_operation_field); eloc_nxt = eeprom_location_field;
            estart_nxt = 1'b1; st_nxt = C_OP_WAIT;
          end
        end
      end
      default: if (e_done) begin
        busy_nxt = 1'b0; tmo_nxt = e_to;  // R08 R12
        if (op_r == OP_READ && !e_to) data_nxt = e_rdata;  // R09
        st_nxt = C_IDLE;
      end
    endcase
    // Soft reset restarts the load as a power-up would.
    if (soft_reset) begin
      st_nxt = C_SIG_RD; busy_nxt = 1'b0; init_nxt = 1'b0; estart_nxt = 1'b0;  // R01
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= C_SIG_RD; op_r <= OP_READ; eop_r <= OP_READ; eloc_r <= 7'h00; estart_r <= 1'b0;
      idx_r <= 3'h0; mac_r <= 48'h000000000000; eeprom_operation_busy <= 1'b0;
      eeprom_timeout_flag <= 1'b0; address_loaded <= 1'b0; init_done <= 1'b0;
      eeprom_data_reg <= 8'h00;
    end else begin
      st_r <= st_nxt; op_r <= op_nxt; eop_r <= eop_nxt; eloc_r <= eloc_nxt;
      estart_r <= estart_nxt; idx_r <= idx_nxt; mac_r <= mac_nxt;
      eeprom_operation_busy <= busy_nxt; eeprom_timeout_flag <= tmo_nxt;
      address_loaded <= loaded_nxt; init_done <= init_nxt; eeprom_data_reg <= data_nxt;
    end
  end

  // ****************************************************************
  // Station address outputs and pin multiplexer
  // ****************************************************************
  // The address outputs are the byte store itself; byte 0 sits lowest.
  assign station_address_low_reg  = mac_r[31:0];
  assign station_address_high_reg = mac_r[47:32];

  // Pins are registered so that switching functions never glitches them.
  always_comb begin
    if (link_disable) begin
      cs_nxt  = 1'b0;  // R13
      clk_nxt = gpio_monitor_sel ? mii_monitor[0] : gpio_value[0];
      io_nxt  = gpio_monitor_sel ? mii_monitor[1] : gpio_value[1];
      oe_nxt  = 1'b1;
    end else begin
      cs_nxt = e_cs; clk_nxt = e_sck; io_nxt = e_dout; oe_nxt = e_oe;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      eeprom_chip_select <= 1'b0; eeprom_serial_clock <= 1'b0;
      eeprom_serial_io_out <= 1'b0; eeprom_serial_io_oe <= 1'b0;
    end else begin
      eeprom_chip_select <= cs_nxt; eeprom_serial_clock <= clk_nxt;
      eeprom_serial_io_out <= io_nxt; eeprom_serial_io_oe <= oe_nxt;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset || soft_reset);

  a_sig_reject: assert property (st_r == C_SIG_WAIT && e_done && e_rdata != `EEC_SIG_VALUE
      |=> st_r == C_IDLE && !address_loaded && init_done)  // R04
    else $error("Bad signature did not end the load.");
  a_sig_accept: assert property (st_r == C_SIG_WAIT && e_done && !e_to
      && e_rdata == `EEC_SIG_VALUE |=> st_r == C_MAC_RD ##1 eloc_r == 7'h01)  // R01
    else $error("Good signature did not start the address load.");
  a_loaded_set: assert property ($rose(address_loaded)
      |-> $past(st_r) == C_MAC_WAIT && $past(idx_r) == 3'h5)  // R03
    else $error("Address-loaded rose before the sixth byte.");
  a_busy_start: assert property (st_r == C_IDLE && busy_set |=> eeprom_operation_busy)  // R08
    else $error("Busy request not taken.");
  a_busy_clear: assert property ($fell(eeprom_operation_busy) |-> $past(e_done))  // R08
    else $error("Busy cleared without completion.");
  a_read_data: assert property (st_r == C_OP_WAIT && op_r == OP_READ && e_done && !e_to
      |=> !eeprom_operation_busy && eeprom_data_reg == $past(e_rdata))  // R09
    else $error("Read data missing when busy cleared.");
  a_timeout_set: assert property (st_r == C_OP_WAIT && e_done && e_to
      |=> eeprom_timeout_flag && !eeprom_operation_busy)  // R12
    else $error("Timeout not reported.");
  a_pins_gpio: assert property (link_disable && !gpio_monitor_sel
      |=> !eeprom_chip_select && eeprom_serial_clock == $past(gpio_value[0]))  // R13
    else $error("Disabled interface did not pass general-purpose output.");

  c_read_done: cover property (st_r == C_OP_WAIT && op_r == OP_READ && e_done);
  c_addr_loaded: cover property ($rose(address_loaded));
  c_timeout: cover property ($rose(eeprom_timeout_flag));
  c_write_done: cover property (st_r == C_OP_WAIT && op_r == OP_WRITE && e_done);

endmodule : eec_serial_eeprom_ctrl
`default_nettype wire

// ===== hw/eec_defines.svh
/*
  Constants for the serial EEPROM controller: link opcodes, addresses, timing counts.
  Assumes a 10 MHz core clock and a three-wire memory organised as 128 x 8 bits.
*/
`ifndef EEC_DEFINES_SVH
`define EEC_DEFINES_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define EEC_CLK_NS        100
`define EEC_SCK_HALF_NS   400
`define EEC_SCK_HALF_CYC  ((`EEC_SCK_HALF_NS + `EEC_CLK_NS - 1) / `EEC_CLK_NS)
`define EEC_TIMEOUT_MS    30
`define EEC_TIMEOUT_CYC   ((`EEC_TIMEOUT_MS * 1000000) / `EEC_CLK_NS)
`define EEC_POLL_SETTLE   5'h04

// ****************************************************************
// Memory layout and link framing
// ****************************************************************
`define EEC_SIG_LOC       7'h00
`define EEC_SIG_VALUE     8'hA5
`define EEC_MAC_BYTES     3'h6
`define EEC_FRAME_CMD     5'h0A
`define EEC_FRAME_DATA    5'h12
`define EEC_READ_BITS     5'h08
`define EEC_OPC_READ      2'h2
`define EEC_OPC_WRITE     2'h1
`define EEC_OPC_ERASE     2'h3
`define EEC_OPC_EXT       2'h0
`define EEC_XA_BULK_ERASE_OP       7'h40
`define EEC_XA_WRITE_EVERYWHERE_OP       7'h20
`define EEC_XA_MODIFY_ENABLE_OP       7'h60
`define EEC_XA_MODIFY_DISABLE_OP       7'h00

`endif

// ===== hw/eec_pkg.sv
/*
  Types shared by the serial EEPROM controller and its link engine.
  Assumes eec_defines.svh supplies the numeric constants.
*/
package eec_pkg;

  // Operations selected in the eeprom_operation_field.
  typedef enum logic [2:0] {
    OP_READ, OP_WRITE, OP_ERASE, OP_BULK_ERASE_OP, OP_WRITE_EVERYWHERE_OP, OP_MODIFY_ENABLE_OP, OP_MODIFY_DISABLE_OP, OP_RELOAD
  } eec_op_t;

  // Link engine states.
  typedef enum logic [2:0] {
    E_IDLE, E_SHIFT, E_READ, E_GAP, E_WAIT, E_END
  } eec_eng_st_t;

  // Controller states.
  typedef enum logic [2:0] {
    C_SIG_RD, C_SIG_WAIT, C_MAC_RD, C_MAC_WAIT, C_IDLE, C_OP_WAIT
  } eec_ctl_st_t;

endpackage : eec_pkg

// ===== hw/eec_link_engine.sv
/*
  Three-wire link engine: frames one operation, shifts data, waits for ready.
  Assumes the controller issues start only while idle; din arrives from a pin.
*/
`timescale 1ns/1ps
`default_nettype none
`include "eec_defines.svh"

module eec_link_engine import eec_pkg::*; #(
  parameter int TIMEOUT_CYC = `EEC_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset,
  // Request from the controller
  input  wire logic       start,
  input  wire logic       abort,
  input  wire eec_op_t    op,
  input  wire logic [6:0] loc,
  input  wire logic [7:0] wdata,
  // Answer to the controller
  output logic            done,
  output logic            timed_out,
  output logic [7:0]      rdata,
  // Link pins
  output logic            cs,
  output logic            sck,
  output logic            dout,
  output logic            dout_oe,
  input  wire logic       din
);

  eec_eng_st_t st_r, st_nxt;
  logic [17:0] frame_r, frame_nxt;
  logic [4:0]  bits_r, bits_nxt;
  logic [2:0]  div_r, div_nxt;
  logic [23:0] to_r, to_nxt;
  logic        rd_r, rd_nxt, wt_r, wt_nxt;
  logic        s1_r, s2_r, s3_r, dq_r, dq_nxt;
  logic        cs_nxt, sck_nxt, dout_nxt, oe_nxt, done_nxt, tmo_nxt;
  logic [7:0]  rdata_nxt;
  logic        tick;
  logic [8:0]  code;

  // ****************************************************************
  // Opcode and address per operation
  // ****************************************************************
  // Seven address bits: the memory is 128 locations of one byte.
  always_comb begin
    case (op)
      OP_READ:  code = {`EEC_OPC_READ, loc};  // R17
      OP_WRITE: code = {`EEC_OPC_WRITE, loc};
      OP_ERASE: code = {`EEC_OPC_ERASE, loc};  // R14
      OP_BULK_ERASE_OP:  code = {`EEC_OPC_EXT, `EEC_XA_BULK_ERASE_OP};  // R15
      OP_WRITE_EVERYWHERE_OP:  code = {`EEC_OPC_EXT, `EEC_XA_WRITE_EVERYWHERE_OP};
      OP_MODIFY_ENABLE_OP:  code = {`EEC_OPC_EXT, `EEC_XA_MODIFY_ENABLE_OP};
      default:  code = {`EEC_OPC_EXT, `EEC_XA_MODIFY_DISABLE_OP};  // R16
    endcase
  end

  assign tick = (div_r == 3'(`EEC_SCK_HALF_CYC - 1));

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // One half-period of the serial clock per tick; the pin input is
  // taken only once two synchroniser stages agree.
  always_comb begin
    st_nxt = st_r; frame_nxt = frame_r; bits_nxt = bits_r; rd_nxt = rd_r; wt_nxt = wt_r;
    cs_nxt = cs; sck_nxt = sck; dout_nxt = dout; oe_nxt = dout_oe; rdata_nxt = rdata;
    done_nxt = 1'b0; tmo_nxt = timed_out;
    dq_nxt = (s2_r == s3_r) ? s3_r : dq_r;
    div_nxt = (st_r == E_IDLE || tick) ? 3'h0 : div_r + 3'h1;
    to_nxt = (st_r == E_IDLE) ? 24'h000000 : to_r + 24'h000001;
    case (st_r)
      E_IDLE: begin
        if (start) begin
          // Start bit, two-bit opcode, seven-bit address, then write data.
          frame_nxt = {1'b1, code, wdata};  // R18
          bits_nxt = (op == OP_WRITE || op == OP_WRITE_EVERYWHERE_OP) ? `EEC_FRAME_DATA : `EEC_FRAME_CMD;
          rd_nxt = (op == OP_READ);
          wt_nxt = (op == OP_WRITE || op == OP_WRITE_EVERYWHERE_OP || op == OP_ERASE || op == OP_BULK_ERASE_OP);
          cs_nxt = 1'b1; sck_nxt = 1'b0; dout_nxt = 1'b1; oe_nxt = 1'b1; tmo_nxt = 1'b0;
          st_nxt = E_SHIFT;
        end
      end
      E_SHIFT: if (tick) begin
        sck_nxt = ~sck;
        if (sck) begin
          frame_nxt = {frame_r[16:0], 1'b0};
          bits_nxt = bits_r - 5'h01;
          dout_nxt = frame_r[16];
          if (bits_r == 5'h01) begin
            dout_nxt = 1'b0; oe_nxt = 1'b0;
            bits_nxt = `EEC_READ_BITS;
            st_nxt = rd_r ? E_READ : (wt_r ? E_GAP : E_END);
          end
        end
      end
      E_READ: if (tick) begin
        sck_nxt = ~sck;
        if (sck) begin
          rdata_nxt = {rdata[6:0], dq_r};
          bits_nxt = bits_r - 5'h01;
          if (bits_r == 5'h01) st_nxt = E_END;
        end
      end
      E_GAP: begin
        // Chip select drops for one half-period, then the busy/ready poll.
        cs_nxt = 1'b0;
        if (tick) begin
          cs_nxt = 1'b1; bits_nxt = `EEC_POLL_SETTLE; st_nxt = E_WAIT;
        end
      end
      // The synchroniser still holds line values from the chip-select gap when the poll opens,
      // so ready is ignored until the pin has passed through all its stages.
      E_WAIT: begin
        if (bits_r != 5'h00) begin
          bits_nxt = bits_r - 5'h01; dq_nxt = 1'b0;
        end else if (dq_r) begin
          st_nxt = E_END;  // R18
        end
      end
      default: begin
        cs_nxt = 1'b0; sck_nxt = 1'b0; done_nxt = 1'b1; st_nxt = E_IDLE;
      end
    endcase
    // A memory that never answers is abandoned after the time limit.
    if (st_r != E_IDLE && st_r != E_END && to_r == 24'(TIMEOUT_CYC - 1)) begin
      st_nxt = E_END; tmo_nxt = 1'b1; oe_nxt = 1'b0;  // R12
      // Hold the count so that it never passes the limit while finishing.
      to_nxt = to_r;
    end
    if (abort) begin
      st_nxt = E_IDLE; cs_nxt = 1'b0; sck_nxt = 1'b0; oe_nxt = 1'b0; done_nxt = 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      st_r <= E_IDLE; frame_r <= 18'h00000; bits_r <= 5'h00; div_r <= 3'h0; to_r <= 24'h000000;
      rd_r <= 1'b0; wt_r <= 1'b0; s1_r <= 1'b0; s2_r <= 1'b0; s3_r <= 1'b0; dq_r <= 1'b0;
      cs <= 1'b0; sck <= 1'b0; dout <= 1'b0; dout_oe <= 1'b0; done <= 1'b0;
      timed_out <= 1'b0; rdata <= 8'h00;
    end else begin
      st_r <= st_nxt; frame_r <= frame_nxt; bits_r <= bits_nxt; div_r <= div_nxt; to_r <= to_nxt;
      rd_r <= rd_nxt; wt_r <= wt_nxt; s1_r <= din; s2_r <= s1_r; s3_r <= s2_r; dq_r <= dq_nxt;
      cs <= cs_nxt; sck <= sck_nxt; dout <= dout_nxt; dout_oe <= oe_nxt; done <= done_nxt;
      timed_out <= tmo_nxt; rdata <= rdata_nxt;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  a_frame_start: assert property ($rose(cs) && st_r == E_SHIFT |-> dout && dout_oe)  // R18
    else $error("Frame did not open with a start bit.");
  a_timeout_bound: assert property (st_r != E_IDLE |-> to_r < 24'(TIMEOUT_CYC))  // R12
    else $error("Operation outlived its time limit.");

endmodule : eec_link_engine
`default_nettype wire

// ===== verification/eec_mem_model.sv
/*
  Behavioural three-wire serial memory, 128 x 8, facing the controller's pins.
  Assumes the controller shifts on falling serial clock edges while chip select is high.
*/
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Serial memory model
// ****************************************************************
module eec_mem_model (
  // Clock and pins from the controller
  input  wire logic core_clk,
  input  wire logic cs,
  input  wire logic sck,
  input  wire logic ctl_out,
  input  wire logic ctl_oe,
  // Resolved data line
  output logic      io
);
  logic [7:0]  mem [0:127];
  logic [17:0] sr        = '0;
  logic [9:0]  last_cmd  = '0;
  logic [7:0]  rd        = '0;
  logic        wr_en     = 1'b0;
  logic        reading   = 1'b0;
  logic        check     = 1'b0;
  logic        no_answer = 1'b0;
  logic        idle_v    = 1'b0;
  logic        rdy       = 1'b0;
  logic        er, eal, wr, wal;
  int          cnt         = 0;
  int          ready_delay = 20;
  realtime     ready_at    = 0;

  // A new frame restarts the bit count.
  always @(posedge cs) cnt = 0;

  // Shift in on rising clock; read data moves out on the same edge.
  always @(posedge sck) begin
    if (cs) begin
      sr = {sr[16:0], io};
      cnt++;
      if (cnt == 10) begin
        last_cmd = sr[9:0];
        reading  = (sr[9:7] == 3'b110);
        rd       = mem[sr[6:0]];
      end else if (reading) begin
        rd = {rd[6:0], ~rd[7]};
      end
    end
  end

  // Frame end: modify operations land here; a disabled memory ignores them.
  always @(negedge cs) begin
    reading = 1'b0;
    er  = cnt == 10 && sr[9:7] == 3'b111;
    eal = cnt == 10 && sr[9:5] == 5'b10010;
    wr  = cnt == 18 && sr[17:15] == 3'b101;
    wal = cnt == 18 && sr[17:13] == 5'b10001;
    if (check) begin
      check = 1'b0;
    end else begin
      if (cnt == 10 && sr[9:7] == 3'b100 && sr[6:5] != 2'b10) wr_en = sr[6];
      if (wr_en && er) mem[sr[6:0]] = 8'hFF;
      if (wr_en && eal) foreach (mem[i]) mem[i] = 8'hFF;
      if (wr_en && wr) mem[sr[14:8]] = sr[7:0];
      if (wr_en && wal) foreach (mem[i]) mem[i] = sr[7:0];
      check    = er || eal || wr || wal;
      ready_at = $realtime + (wr_en ? ready_delay * 100.0 : 0.0);
    end
  end

  // A released line toggles every clock so that stale data never looks valid.
  always @(posedge core_clk) begin
    idle_v <= ~idle_v;
    rdy    <= !no_answer && ($realtime >= ready_at);
  end

  assign io = ctl_oe ? ctl_out : (cs && reading) ? rd[7] : (cs && check) ? rdy : idle_v;
endmodule : eec_mem_model

`default_nettype wire

// ===== verification/testbench.sv
/*
  Self-checking bench for the serial EEPROM controller with a memory model.
  Assumes the controller is built with a short timeout count for simulation.
*/
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", nm, ex, gt); end end

// ****************************************************************
// Bench top
// ****************************************************************
module testbench;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1, soft_reset = 1'b0, busy_set = 1'b0, data_wr = 1'b0;
  logic [2:0]  op_f = '0;
  logic [6:0]  loc_f = '0;
  logic [7:0]  wval = '0;
  logic        link_disable = 1'b0, mon_sel = 1'b0;
  logic [1:0]  gpio_value = '0, mii_monitor = '0;
  logic        busy, tflag, loaded, init_done, cs, sck, io_out, io_oe, io;
  logic [7:0]  data_q;
  logic [31:0] addr_lo;
  logic [15:0] addr_hi;
  int          mismatches = 0, cmp_count = 0, cyc = 0, last_n = 0;

  // Clock at 10 MHz.
  always #50 core_clk = ~core_clk;

  eec_serial_eeprom_ctrl #(.TIMEOUT_CYC(2000)) dut_u (
    .core_clk(core_clk), .reset(reset), .soft_reset(soft_reset),
    .eeprom_operation_field(op_f), .eeprom_location_field(loc_f), .busy_set(busy_set),
    .data_wr_value(wval), .data_wr(data_wr), .eeprom_operation_busy(busy),
    .eeprom_timeout_flag(tflag), .address_loaded(loaded), .init_done(init_done),
    .eeprom_data_reg(data_q), .station_address_low_reg(addr_lo),
    .station_address_high_reg(addr_hi), .link_disable(link_disable),
    .gpio_monitor_sel(mon_sel), .gpio_value(gpio_value), .mii_monitor(mii_monitor),
    .eeprom_chip_select(cs), .eeprom_serial_clock(sck), .eeprom_serial_io_out(io_out),
    .eeprom_serial_io_oe(io_oe), .eeprom_serial_io_in(io));

  eec_mem_model part_u (.core_clk(core_clk), .cs(cs), .sck(sck), .ctl_out(io_out),
    .ctl_oe(io_oe), .io(io));

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic wrap_up;
    if (mismatches == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up

  // Signature plus six address bytes of base + 11h * i.
  task automatic load_sig(input logic [7:0] sig, input logic [7:0] base);
    part_u.mem[0] = sig;
    for (int i = 1; i < 7; i++) part_u.mem[i] = base + 8'(8'h11 * i);
  endtask : load_sig

  // Bounded wait for the reset-time load; no command goes out before it.
  task automatic wait_init(input logic [7:0] base);
    int n;
    n = 0;
    while (init_done !== 1'b1 && n < 3000) begin @(negedge core_clk); n++; end
    `CHK("loaded", 1'b1, loaded)
    `CHK("addr_lo", {base + 8'h44, base + 8'h33, base + 8'h22, base + 8'h11}, addr_lo)
    `CHK("addr_hi", {base + 8'h66, base + 8'h55}, addr_hi)
  endtask : wait_init

  // Set busy with an operation, then wait for completion under a bound.
  task automatic run_op(input logic [2:0] code, input logic [6:0] loc);
    @(negedge core_clk);
    op_f     = code;
    loc_f    = loc;
    busy_set = 1'b1;
    @(negedge core_clk);
    busy_set = 1'b0;
    `CHK("busy_rise", 1'b1, busy)
    last_n = 0;
    while (busy !== 1'b0 && last_n < 3000) begin @(negedge core_clk); last_n++; end
    `CHK("busy_fall", 1'b1, last_n < 3000)
  endtask : run_op

  // Data goes into the data register before the write is selected.
  task automatic write_op(input logic [2:0] code, input logic [6:0] loc, input logic [7:0] v);
    @(negedge core_clk);
    wval    = v;
    data_wr = 1'b1;
    @(negedge core_clk);
    data_wr = 1'b0;
    run_op(code, loc);
  endtask : write_op

  task automatic read_chk(input logic [6:0] loc, input logic [7:0] exp);
    run_op(3'h0, loc);
    `CHK("rdata", exp, data_q)
    `CHK("frame", {3'b110, loc}, part_u.last_cmd)
  endtask : read_chk

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    for (int i = 0; i < 128; i++) part_u.mem[i] = 8'h00;
    load_sig(8'hA5, 8'h00);
    part_u.mem[127] = 8'hC3;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    reset = 1'b0;
    wait_init(8'h00);
    read_chk(7'h05, 8'h55);
    read_chk(7'h7F, 8'hC3);
    write_op(3'h1, 7'h09, 8'h5A);
    read_chk(7'h09, 8'h00);
    run_op(3'h5, 7'h00);
    write_op(3'h1, 7'h09, 8'h5A);
    read_chk(7'h09, 8'h5A);
    run_op(3'h2, 7'h09);
    read_chk(7'h09, 8'hFF);
    write_op(3'h4, 7'h00, 8'h3C);
    read_chk(7'h64, 8'h3C);
    run_op(3'h3, 7'h00);
    read_chk(7'h00, 8'hFF);
    // Slow but in-time answer, then no answer at all.
    part_u.ready_delay = 1000;
    write_op(3'h1, 7'h03, 8'h77);
    `CHK("no_tflag", 1'b0, tflag)
    `CHK("slow_len", 1'b1, last_n > 1000)
    read_chk(7'h03, 8'h77);
    part_u.ready_delay = 20;
    part_u.no_answer = 1'b1;
    write_op(3'h1, 7'h04, 8'h12);
    `CHK("tflag", 1'b1, tflag)
    `CHK("to_len", 1'b1, last_n > 1900 && last_n < 2100)
    part_u.no_answer = 1'b0;
    read_chk(7'h04, 8'h12);
    `CHK("tflag_clr", 1'b0, tflag)
    run_op(3'h7, 7'h00);
    `CHK("reload_fail", 1'b0, loaded)
    run_op(3'h6, 7'h00);
    write_op(3'h1, 7'h02, 8'h77);
    read_chk(7'h02, 8'hFF);
    load_sig(8'hA5, 8'h20);
    run_op(3'h7, 7'h00);
    `CHK("reload_ok", 1'b1, loaded)
    `CHK("reload_lo", 32'h64534231, addr_lo)
    load_sig(8'hA5, 8'h40);
    @(negedge core_clk);
    soft_reset = 1'b1;
    @(negedge core_clk);
    soft_reset = 1'b0;
    @(negedge core_clk);
    `CHK("init_clr", 1'b0, init_done)
    wait_init(8'h40);
    // Disabled interface: pins follow general outputs or monitors.
    link_disable = 1'b1;
    for (int k = 0; k < 4; k++) begin
      mon_sel     = k[1];
      gpio_value  = k[1] ? 2'b00 : k[1:0] ^ 2'b01;
      mii_monitor = k[1] ? k[1:0] ^ 2'b11 : 2'b00;
      repeat (3) @(negedge core_clk);
      `CHK("pin_clk", k[1] ? mii_monitor[0] : gpio_value[0], sck)
      `CHK("pin_io", {1'b1, k[1] ? mii_monitor[1] : gpio_value[1]}, {io_oe, io_out})
      `CHK("pin_cs", 1'b0, cs)
    end
    wrap_up();
  end

  // Hang guard.
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      wrap_up();
    end
  end
endmodule : testbench

`default_nettype wire
